// [logic/smes_event_status.sv]
// Read-to-clear event status register of the switch monitor
//
// Operation
// - Status bits 23 to 14 are reserved and always read zero.
// - A status read clears every event flag until a new event occurs.
// - Failed factory settings self-check sets bit 13 and the power-on flag.
// - Enabled converter self-diagnostic fault sets bit 12.
// - Enabled wetting-current diagnostic fault sets bit 11.
// - Supply state change against pair one thresholds sets bit 10.
// - Supply state change against pair zero thresholds sets bit 9.
// - Bit 8 set when checksum finishes; zero while running, before, after read.
// - Finished checksum result becomes readable at offset 3h.
// - Under-voltage onset and end both set bit 7.
// - Over-voltage onset and end both set bit 6.
`timescale 1ns/1ps
`default_nettype none
`include "smes_params.svh"
module smes_event_status
	import smes_pkg::*;
#(
	parameter int STAT_WIDTH = `SMES_STAT_WIDTH,
	parameter int CRC_WIDTH = 16
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Register access from the serial front end
	input wire logic stat_read_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_read_i,
	output logic [STAT_WIDTH-1:0] stat_word_o,
	output logic [CRC_WIDTH-1:0] reg_rdata_o,
	// Diagnostic event sources
	input wire logic factory_check_fail_i,
	input wire logic conv_diag_en_i,
	input wire logic conv_fault_i,
	input wire logic wetting_current_error_en_i,
	input wire logic wet_fault_i,
	// Supply monitoring levels
	input wire logic supply_meas_en_i,
	input wire logic supply_pair0_threshold_a_i,
	input wire logic supply_pair0_threshold_b_i,
	input wire logic supply_pair1_threshold_a_i,
	input wire logic supply_pair1_threshold_b_i,
	input wire logic undervoltage_i,
	input wire logic overvoltage_i,
	// Checksum engine
	input wire logic checksum_start_i,
	input wire logic checksum_finish_i,
	input wire logic [CRC_WIDTH-1:0] checksum_value_i,
	// Power-on flag request
	output logic power_on_set_o
);
	// ------------------------------------------------------------
	// Level change detection
	// ------------------------------------------------------------
	logic w0a_chg;
	logic w0b_chg;
	logic w1a_chg;
	logic w1b_chg;
	logic uv_chg;
	logic ov_chg;

	smes_level_edge u_w0a (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.level_i(supply_pair0_threshold_a_i),
		.enable_i(supply_meas_en_i),
		.change_o(w0a_chg)
	);
	smes_level_edge u_w0b (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.level_i(supply_pair0_threshold_b_i),
		.enable_i(supply_meas_en_i),
		.change_o(w0b_chg)
	);
	smes_level_edge u_w1a (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.level_i(supply_pair1_threshold_a_i),
		.enable_i(supply_meas_en_i),
		.change_o(w1a_chg)
	);
	smes_level_edge u_w1b (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.level_i(supply_pair1_threshold_b_i),
		.enable_i(supply_meas_en_i),
		.change_o(w1b_chg)
	);
	smes_level_edge u_uv (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.level_i(undervoltage_i),
		.enable_i(1'b1),
		.change_o(uv_chg)
	);
	smes_level_edge u_ov (
		.ref_clk_i(ref_clk_i),
		.rst_b_i(rst_b_i),
		.level_i(overvoltage_i),
		.enable_i(1'b1),
		.change_o(ov_chg)
	);

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------
	// Diagnostic fault counts only while its feature is enabled
	function automatic logic gated_fault(input logic enable, input logic fault);
		return enable && fault;
	endfunction

	// Either threshold of a pair changing flags the pair
	function automatic logic pair_change(input logic a_chg, input logic b_chg);
		return a_chg || b_chg;
	endfunction

	// ------------------------------------------------------------
	// Checksum tracking
	// ------------------------------------------------------------
	smes_crc_state_t crc_state;
	smes_crc_state_t next_crc_state;
	logic [CRC_WIDTH-1:0] crc_result;
	logic [CRC_WIDTH-1:0] next_crc_result;
	logic crc_done;

	always_comb begin
		next_crc_state = crc_state;
		next_crc_result = crc_result;
		crc_done = 1'b0;
		unique case (crc_state)
			SMES_CRC_IDLE: begin
				if (checksum_start_i) begin
					next_crc_state = SMES_CRC_RUN;
				end
			end
			SMES_CRC_RUN: begin
				if (checksum_finish_i) begin
					next_crc_state = SMES_CRC_IDLE;
					next_crc_result = checksum_value_i;
					crc_done = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			crc_state <= SMES_CRC_IDLE;
			crc_result <= `SMES_CRC_RESET;
		end else begin
			crc_state <= next_crc_state;
			crc_result <= next_crc_result;
		end
	end

	// ------------------------------------------------------------
	// Event gathering
	// ------------------------------------------------------------
	logic [STAT_WIDTH-1:0] events;

	always_comb begin
		events = '0;
		events[`SMES_BIT_FACTORY_CHECK] = factory_check_fail_i;
		events[`SMES_BIT_CONV_SELFTEST] = gated_fault(conv_diag_en_i, conv_fault_i);
		events[`SMES_BIT_WETTING] = gated_fault(wetting_current_error_en_i, wet_fault_i);
		events[`SMES_BIT_WINDOW1] = pair_change(w1a_chg, w1b_chg);
		events[`SMES_BIT_WINDOW0] = pair_change(w0a_chg, w0b_chg);
		events[`SMES_BIT_CHECKSUM] = crc_done;
		events[`SMES_BIT_UNDERVOLT] = uv_chg;
		events[`SMES_BIT_OVERVOLT] = ov_chg;
	end

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	logic [STAT_WIDTH-1:0] flags;
	logic [STAT_WIDTH-1:0] next_flags;

	always_comb begin
		next_flags = flags;
		if (stat_read_i) begin
			next_flags = '0;
		end
		if (checksum_start_i) begin
			next_flags[`SMES_BIT_CHECKSUM] = 1'b0;
		end
		// Events ORed in last so a coinciding read cannot drop them
		next_flags = next_flags | events;
		next_flags[STAT_WIDTH-1:`SMES_RESERVED_LSB] = '0;
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			flags <= `SMES_STAT_RESET;
		end else begin
			flags <= next_flags;
		end
	end

	// ------------------------------------------------------------
	// Register read data
	// ------------------------------------------------------------
	logic [CRC_WIDTH-1:0] rdata;
	logic [CRC_WIDTH-1:0] next_rdata;

	always_comb begin
		next_rdata = rdata;
		if (reg_read_i) begin
			// Only the checksum result lives here; other offsets read zero
			next_rdata = (reg_addr_i == `SMES_CRC_OFFSET) ? crc_result : '0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata <= `SMES_CRC_RESET;
		end else begin
			rdata <= next_rdata;
		end
	end

	// ------------------------------------------------------------
	// Power-on flag request
	// ------------------------------------------------------------
	logic por_set;
	logic next_por_set;

	always_comb begin
		next_por_set = factory_check_fail_i;
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			por_set <= 1'b0;
		end else begin
			por_set <= next_por_set;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign stat_word_o = flags;
	assign reg_rdata_o = rdata;
	assign power_on_set_o = por_set;
endmodule // smes_event_status
`default_nettype wire

// [logic/smes_level_edge.sv]
// Change detector for a supply level: pulses on every state change while enable_i is high
`timescale 1ns/1ps
`default_nettype none
module smes_level_edge (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Level in, pulse out
	input wire logic level_i,
	input wire logic enable_i,
	output logic change_o
);
	logic level_q;
	logic next_level_q;
	logic change;
	logic next_change;

	always_comb begin
		next_level_q = level_i;
		next_change = enable_i && (level_i != level_q);
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			level_q <= 1'b0;
			change <= 1'b0;
		end else begin
			level_q <= next_level_q;
			change <= next_change;
		end
	end

	assign change_o = change;
endmodule // smes_level_edge
`default_nettype wire

// [logic/smes_params.svh]
// Constants for the switch monitor event status block
`ifndef SMES_PARAMS_SVH
`define SMES_PARAMS_SVH
`define SMES_STAT_WIDTH 24
`define SMES_CRC_OFFSET 8'h03
`define SMES_BIT_FACTORY_CHECK 13
`define SMES_BIT_CONV_SELFTEST 12
`define SMES_BIT_WETTING 11
`define SMES_BIT_WINDOW1 10
`define SMES_BIT_WINDOW0 9
`define SMES_BIT_CHECKSUM 8
`define SMES_BIT_UNDERVOLT 7
`define SMES_BIT_OVERVOLT 6
`define SMES_RESERVED_LSB 14
`define SMES_STAT_RESET 24'h000000
`define SMES_CRC_RESET 16'h0000
`endif

// [logic/smes_pkg.sv]
// Types for the switch monitor event status block
package smes_pkg;
	typedef enum logic [1:0] {
		SMES_CRC_IDLE,
		SMES_CRC_RUN
	} smes_crc_state_t;
endpackage

// [sim/smes_event_status_chk.sv]
// Checker for the event status block
`timescale 1ns/1ps
`default_nettype none
module smes_chk #(
	parameter int STAT_WIDTH = 24,
	parameter int CRC_WIDTH = 16
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Host access and results
	input wire logic stat_read_i,
	input wire logic [STAT_WIDTH-1:0] stat_word_o,
	input wire logic power_on_set_o,
	// Diagnostic event sources
	input wire logic factory_check_fail_i,
	input wire logic conv_diag_en_i,
	input wire logic conv_fault_i,
	input wire logic wetting_current_error_en_i,
	input wire logic wet_fault_i,
	// Supply levels
	input wire logic supply_meas_en_i,
	input wire logic supply_pair0_threshold_a_i,
	input wire logic supply_pair0_threshold_b_i,
	input wire logic supply_pair1_threshold_a_i,
	input wire logic supply_pair1_threshold_b_i,
	input wire logic undervoltage_i,
	input wire logic overvoltage_i,
	// Checksum engine
	input wire logic checksum_start_i,
	input wire logic checksum_finish_i
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	wire cv = conv_diag_en_i && conv_fault_i;
	wire wt = wetting_current_error_en_i && wet_fault_i;
	logic crc_running;
	// Calculation in flight, from start to finish
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			crc_running <= 1'b0;
		end else if (checksum_start_i) begin
			crc_running <= 1'b1;
		end else if (checksum_finish_i) begin
			crc_running <= 1'b0;
		end
	end
	a_reserved_zero: assert property (stat_word_o[23:14] == 10'h000)
		else $error("reserved set");
	a_read_clears: assert property (stat_read_i && !factory_check_fail_i && !cv && !wt
		|=> stat_word_o[13:11] == 3'h0) else $error("not cleared");
	a_factory_sets: assert property (factory_check_fail_i |=> stat_word_o[13]
		&& power_on_set_o) else $error("factory lost");
	a_conv_sets: assert property (cv |=> stat_word_o[12]) else $error("conv lost");
	a_wet_sets: assert property (wt |=> stat_word_o[11]) else $error("wet lost");
	a_under_edge: assert property ($changed(undervoltage_i) |-> ##2 stat_word_o[7])
		else $error("uv lost");
	a_over_edge: assert property ($changed(overvoltage_i) |-> ##2 stat_word_o[6])
		else $error("ov lost");
	a_window_edge: assert property (supply_meas_en_i &&
		$changed({supply_pair0_threshold_a_i, supply_pair0_threshold_b_i})
		|-> ##2 stat_word_o[9]) else $error("window lost");
	a_window1_edge: assert property (supply_meas_en_i &&
		$changed({supply_pair1_threshold_a_i, supply_pair1_threshold_b_i})
		|-> ##2 stat_word_o[10]) else $error("window1 lost");
	a_start_clears: assert property (checksum_start_i |=> !stat_word_o[8])
		else $error("done early");
	a_done_sets: assert property (crc_running && checksum_finish_i |=> stat_word_o[8])
		else $error("done lost");
	a_por_only_fail: assert property (!factory_check_fail_i |=> !power_on_set_o)
		else $error("stray power-on request");
	c_factory_read: cover property (stat_read_i && stat_word_o[13]);
	c_crc_done: cover property (stat_word_o[8]);
	c_read_event: cover property (stat_read_i && cv);
	c_uv_change: cover property ($changed(undervoltage_i));
endmodule // smes_chk
bind smes_event_status smes_chk #(
	.STAT_WIDTH(STAT_WIDTH),
	.CRC_WIDTH(CRC_WIDTH)
) i_chk (
	.ref_clk_i(ref_clk_i),
	.rst_b_i(rst_b_i),
	.stat_read_i(stat_read_i),
	.stat_word_o(stat_word_o),
	.power_on_set_o(power_on_set_o),
	.factory_check_fail_i(factory_check_fail_i),
	.conv_diag_en_i(conv_diag_en_i),
	.conv_fault_i(conv_fault_i),
	.wetting_current_error_en_i(wetting_current_error_en_i),
	.wet_fault_i(wet_fault_i),
	.supply_meas_en_i(supply_meas_en_i),
	.supply_pair0_threshold_a_i(supply_pair0_threshold_a_i),
	.supply_pair0_threshold_b_i(supply_pair0_threshold_b_i),
	.supply_pair1_threshold_a_i(supply_pair1_threshold_a_i),
	.supply_pair1_threshold_b_i(supply_pair1_threshold_b_i),
	.undervoltage_i(undervoltage_i),
	.overvoltage_i(overvoltage_i),
	.checksum_start_i(checksum_start_i),
	.checksum_finish_i(checksum_finish_i)
);
`default_nettype wire

// [sim/smes_host_mdl.sv]
// Host model reading the status word
`timescale 1ns/1ps
`default_nettype none
module smes_host_mdl (
	// Clock and read request
	input wire logic ref_clk_i,
	input wire logic go_i,
	// Status word from the block
	input wire logic [23:0] stat_word_i,
	// Read strobe and captured results
	output logic stat_read_o = 1'b0,
	output logic [23:0] word_o,
	output logic soft_rst_o = 1'b0
);
	always @(posedge ref_clk_i) begin
		if (stat_read_o) word_o <= stat_word_i;
		if (stat_read_o) soft_rst_o <= stat_word_i[13];
		stat_read_o <= #1 go_i;
	end
endmodule // smes_host_mdl
`default_nettype wire

// [sim/test_switch_monitor_event_status.sv]
// Bench for the event status block
`timescale 1ns/1ps
`default_nettype none
module test_switch_monitor_event_status;
	logic ref_clk_i = 0, rst_b_i = 0, go = 0, rrd = 0, sread, por, srst;
	logic [13:0] ev = '0;
	logic [13:0] rv = '0;
	logic [7:0] adr = '0;
	logic [15:0] val = '0, rdata;
	logic [23:0] word, hword;
	int num_errors = 0, compares = 0;
	logic [13:0] pv [9] = '{14'h0001, 14'h0006, 14'h0004, 14'h0018, 14'h0400,
		14'h0800, 14'h0220, 14'h0060, 14'h0080};
	int eb [9] = '{13, 12, -1, 11, 7, 6, 10, 9, -1};
	smes_event_status i_dut (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .stat_read_i(sread),
		.reg_addr_i(adr), .reg_read_i(rrd), .stat_word_o(word), .reg_rdata_o(rdata),
		.factory_check_fail_i(ev[0]), .conv_diag_en_i(ev[1]),
		.conv_fault_i(ev[2]), .wetting_current_error_en_i(ev[3]), .wet_fault_i(ev[4]),
		.supply_meas_en_i(ev[5]), .supply_pair0_threshold_a_i(ev[6]),
		.supply_pair0_threshold_b_i(ev[7]), .supply_pair1_threshold_a_i(ev[8]),
		.supply_pair1_threshold_b_i(ev[9]), .undervoltage_i(ev[10]), .overvoltage_i(ev[11]),
		.checksum_start_i(ev[12]), .checksum_finish_i(ev[13]), .checksum_value_i(val),
		.power_on_set_o(por));
	smes_host_mdl i_host (.ref_clk_i(ref_clk_i), .go_i(go), .stat_word_i(word),
		.stat_read_o(sread), .word_o(hword), .soft_rst_o(srst));
	function automatic logic [23:0] exp_of(int b);
		return b < 0 ? 24'h000000 : 24'h000001 << b;
	endfunction
	function automatic logic [23:0] exp_direct(logic [13:0] v);
		logic [23:0] e;
		e = 24'h000000;
		e[12] = v[1] & v[2];
		e[11] = v[3] & v[4];
		return e;
	endfunction
	task automatic end_sim();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	task automatic cmpw(logic [23:0] g, logic [23:0] e);
		compares++;
		if (g !== e) num_errors++;
		if (g !== e) $display("[FAIL] %0t word %h exp %h", $time, g, e);
	endtask
	task automatic cmpd(logic [15:0] g, logic [15:0] e);
		compares++;
		if (g !== e) num_errors++;
		if (g !== e) $display("[FAIL] %0t rdata %h exp %h", $time, g, e);
	endtask
	task automatic cmpb(logic g, logic e);
		compares++;
		if (g !== e) num_errors++;
		if (g !== e) $display("[FAIL] %0t por %b exp %b", $time, g, e);
	endtask
	task automatic rd(logic [23:0] e);
		go = 1;
		tick(1);
		go = 0;
		tick(2);
		cmpw(hword, e);
	endtask
	task automatic rreg(logic [7:0] a, logic [15:0] e);
		adr = a;
		rrd = 1;
		tick(1);
		rrd = 0;
		tick(1);
		cmpd(rdata, e);
	endtask
	task automatic pulse(logic [13:0] v);
		ev = v;
		tick(1);
		ev = '0;
		cmpb(por, v[0]);
		tick(3 + $urandom % 4);
	endtask
	task automatic rst();
		rst_b_i = 0;
		tick(5);
		rst_b_i = 1;
	endtask
	initial forever #5 ref_clk_i = ~ref_clk_i;
	initial begin
		#20us;
		num_errors++;
		end_sim();
	end
	initial begin
		void'($urandom(42));
		rst();
		rd(24'h000000);
		for (int k = 0; k < 9; k++) begin
			pulse(pv[k]);
			rd(exp_of(eb[k]));
			if (srst === 1'b1) rst();
			rd(24'h000000);
			$display("event test %0d done", k);
		end
		pulse(14'h1000);
		rd(24'h000000);
		val = 16'($urandom);
		pulse(14'h2000);
		rreg(8'h03, val);
		rreg(8'h04, 16'h0000);
		rd(exp_of(8));
		pulse(14'h2000);
		rd(24'h000000);
		$display("checksum test done");
		go = 1;
		tick(1);
		go = 0;
		ev = 14'h0006;
		tick(1);
		ev = '0;
		tick(1);
		cmpw(hword, 24'h000000);
		rd(exp_of(12));
		rd(24'h000000);
		$display("overlap test done");
		for (int k = 0; k < 16; k++) begin
			rv = {9'h000, 4'($urandom), 1'b0};
			pulse(rv);
			rd(exp_direct(rv));
		end
		$display("random test done");
		end_sim();
	end
endmodule // test_switch_monitor_event_status
`default_nettype wire
